// ==== spibs_pkg.sv ====
// Shared constants for the serial port buffer-status block
`default_nettype none
package spibs_pkg;
   localparam int          BYTE_BITS    = 8;   // Bits per serial byte
   localparam int          CLK_NS       = 8;   // System clock period, ns
   localparam int          M_BIT_NS     = 64;  // Master bit period, ns
   localparam int          M_BIT_CYC    = M_BIT_NS / CLK_NS;
   localparam int          M_HALF_CYC   = M_BIT_CYC / 2;
   localparam int          M_SAMPLE_CYC = M_BIT_CYC - 2;
   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam logic [2:0]  CYC_LAST     = 3'(M_BIT_CYC - 1);
   localparam logic [2:0]  CYC_HALF     = 3'(M_HALF_CYC);
   localparam logic [2:0]  CYC_SAMPLE   = 3'(M_SAMPLE_CYC);
   localparam logic        SRE_RESET    = 1'h1; // Shift reg empty at reset
   localparam logic        RXE_RESET    = 1'h1; // Rx buffer empty at reset
   localparam logic [7:0]  IDLE_BYTE    = 8'hff; // Sent when nothing queued
   typedef enum logic [1:0] {
      SPIBS_M_IDLE = 2'b01,
      SPIBS_M_SHIFT = 2'b10
   } spibs_mstate_t;
endpackage : spibs_pkg
`default_nettype wire

// ==== spibs_buf_if.sv ====
// Byte stream carrier between the top module and its receive buffer
`timescale 1ns/100ps
`default_nettype none
interface spibs_buf_if;
   logic [7:0] in_data;   // Byte offered to the buffer
   logic       in_valid;  // Offer stands
   logic       in_ready;  // Buffer has a free entry
   logic [7:0] out_data;  // Oldest byte held
   logic       out_valid; // Buffer holds a byte
   logic       out_ready; // Consumer takes the byte
   modport buffer (input in_data, in_valid, out_ready,
                   output in_ready, out_data, out_valid);
   modport user (output in_data, in_valid, out_ready,
                 input in_ready, out_data, out_valid);
endinterface : spibs_buf_if
`default_nettype wire

// ==== spibs_buf.sv ====
// Two-entry receive buffer, head always in entry 0
`timescale 1ns/100ps
`default_nettype none
module spibs_buf (
   input  wire logic    CLK,
   input  wire logic    RST,
   spibs_buf_if.buffer  bus
);
   import spibs_pkg::*;

   logic [7:0] mem [2];  // Entry 0 is the head
   logic [1:0] vld;      // Per-entry occupancy
   logic       push;
   logic       pop;

   assign push = bus.in_valid & ~vld[1];
   assign pop  = bus.out_valid & bus.out_ready;
   assign bus.in_ready  = ~vld[1];
   assign bus.out_data  = mem[0];
   assign bus.out_valid = vld[0];

   // Shift-style storage keeps the head a plain flop for the pins
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mem[0] <= 8'h00;
         mem[1] <= 8'h00;
         vld    <= 2'h0;
      end else if (pop & push) begin
         if (vld[1]) begin
            mem[0] <= mem[1];
            mem[1] <= bus.in_data;
         end else begin
            mem[0] <= bus.in_data;
         end
      end else if (pop) begin
         mem[0] <= mem[1];
         vld    <= {1'b0, vld[1]};
      end else if (push) begin
         if (!vld[0]) begin
            mem[0] <= bus.in_data;
            vld[0] <= 1'b1;
         end else begin
            mem[1] <= bus.in_data;
            vld[1] <= 1'b1;
         end
      end
   end

   // Full buffer must refuse, so nothing is overwritten
   full_guard_a: assert property (@(posedge CLK) disable iff (RST)
      (vld[1] && !pop) |=> (vld[1] && mem[1] == $past(mem[1])))
      else $error("full buffer entry changed without a pop");
endmodule : spibs_buf
`default_nettype wire

// ==== spibs_top.sv ====
// Serial port with shift-register and receive-buffer empty flags
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// (R1) Slave: shift empty set when idle
// (R2) Shift empty cleared by load or clock
// (R3) Master: shift empty always one
// (R4) Slave: rx empty set when drained
// (R5) Slave: rx empty cleared by unread byte
// (R6) Master: rx empty always one
// (R7) Slave samples data-in at bit center
// (R8) Master samples one clock before bit end
// (R9) Empty flags are read-only status
module spibs_top (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       SCK_LINK,
   input  wire logic       MASTER_MODE,
   input  wire logic       MOSI_I,
   input  wire logic       MISO_I,
   output logic            SCK_O,
   output logic            SCK_OE_N,
   output logic            MOSI_O,
   output logic            MOSI_OE_N,
   output logic            MISO_O,
   output logic            MISO_OE_N,
   input  wire logic [7:0] TX_DATA,
   input  wire logic       TX_VALID,
   output logic            TX_READY,
   output logic [7:0]      RX_DATA,
   output logic            RX_VALID,
   input  wire logic       RX_READY,
   output logic            SHIFT_REG_EMPTY_FLAG,
   output logic            RX_BUFFER_EMPTY_FLAG
);
   import spibs_pkg::*;

   // ---- Link domain (serial clock from the far master) ----
   logic [2:0] l_cnt;      // Bit position within byte
   logic [7:0] l_in;       // Incoming shift register
   logic [7:0] l_tx;       // Outgoing shift register
   logic [7:0] l_rx;       // Last whole byte received
   logic       l_rx_tgl;   // Flips per whole byte
   logic       l_edge_tgl; // Flips per rising serial clock edge
   logic       l_ack;      // Transmit byte taken
   logic [1:0] l_req_s;    // Request synchroniser
   // ---- System domain ----
   logic [7:0] tx_hold;    // Transmit buffer
   logic       tx_req;     // Transmit buffer offered to link
   logic [2:0] s1, s2, s3; // Synchronisers {ack, byte, edge}
   logic       ack_rise, byte_evt, edge_evt;
   logic       miso_m1, miso_m2; // Master data-in synchroniser
   spibs_mstate_t m_state;
   logic [2:0] m_cyc;      // Cycle within master bit
   logic [2:0] m_bit;      // Master bit index
   logic [7:0] m_sr;       // Master outgoing byte
   logic [7:0] m_in;       // Master incoming byte
   logic       m_samp;     // Master sampling strobe
   logic [7:0] rx_cap;     // Byte waiting for the buffer
   logic       rx_pend;    // Byte waiting for the buffer
   logic       m_start;
   logic       next_sre;

   spibs_buf_if rxq ();

   spibs_buf u_buf (
      .CLK (CLK),
      .RST (RST),
      .bus (rxq.buffer)
   );

   assign rxq.in_data   = rx_cap;
   assign rxq.in_valid  = rx_pend;
   assign rxq.out_ready = RX_READY;
   assign RX_DATA       = rxq.out_data;
   assign RX_VALID      = rxq.out_valid;

   // Request level into the link domain
   always_ff @(posedge SCK_LINK or posedge RST) begin
      if (RST) begin
         l_req_s <= 2'h0;
      end else begin
         l_req_s <= {l_req_s[0], tx_req};
      end
   end

   // Rising serial edge falls mid-bit, so data-in is taken here
   always_ff @(posedge SCK_LINK or posedge RST) begin
      if (RST) begin
         l_cnt      <= 3'h0;
         l_in       <= 8'h00;
         l_rx       <= 8'h00;
         l_rx_tgl   <= 1'b0;
         l_edge_tgl <= 1'b0;
      end else begin
         l_in       <= {l_in[6:0], MOSI_I}; // R7
         l_cnt      <= l_cnt + 3'h1;
         l_edge_tgl <= ~l_edge_tgl;
         if (l_cnt == BIT_LAST) begin
            l_rx     <= {l_in[6:0], MOSI_I};
            l_rx_tgl <= ~l_rx_tgl;
         end
      end
   end

   // Outgoing byte: reload at byte end, idle pattern if none queued
   always_ff @(posedge SCK_LINK or posedge RST) begin
      if (RST) begin
         l_tx   <= IDLE_BYTE;
         l_ack  <= 1'b0;
         MISO_O <= 1'b1;
      end else if (l_cnt == BIT_LAST) begin
         if (l_req_s[1] && !l_ack) begin
            l_tx   <= tx_hold;
            MISO_O <= tx_hold[7];
            l_ack  <= 1'b1;
         end else begin
            l_tx   <= IDLE_BYTE;
            MISO_O <= IDLE_BYTE[7];
         end
      end else begin
         l_tx   <= {l_tx[6:0], 1'b1};
         MISO_O <= l_tx[6];
         if (!l_req_s[1]) begin
            l_ack <= 1'b0;
         end
      end
   end

   // Events back into the system domain; stages two and three are compared, stage one is never looked at
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1      <= 3'h0;
         s2      <= 3'h0;
         s3      <= 3'h0;
         miso_m1 <= 1'b0;
         miso_m2 <= 1'b0;
      end else begin
         s1      <= {l_ack, l_rx_tgl, l_edge_tgl};
         s2      <= s1;
         s3      <= s2;
         miso_m1 <= MISO_I;
         miso_m2 <= miso_m1;
      end
   end

   assign ack_rise = s2[2] & ~s3[2];
   assign byte_evt = s2[1] ^ s3[1];
   assign edge_evt = s2[0] ^ s3[0];
   assign m_start  = MASTER_MODE & (m_state == SPIBS_M_IDLE) & ~TX_READY;
   assign m_samp   = (m_state == SPIBS_M_SHIFT) & (m_cyc == CYC_SAMPLE);

   // Transmit buffer; data stays still while offered across domains
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tx_hold  <= 8'h00;
         TX_READY <= 1'b1;
         tx_req   <= 1'b0;
      end else if (TX_VALID && TX_READY) begin
         tx_hold  <= TX_DATA;
         TX_READY <= 1'b0;
      end else if (m_start || ack_rise) begin
         TX_READY <= 1'b1;
         tx_req   <= 1'b0;
      end else if (!MASTER_MODE && !TX_READY && !tx_req && !s2[2]) begin
         tx_req   <= 1'b1;
      end
   end

   // Master engine: serial clock high in second half of each bit
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         m_state <= SPIBS_M_IDLE;
         m_cyc   <= 3'h0;
         m_bit   <= 3'h0;
         m_sr    <= 8'h00;
         m_in    <= 8'h00;
      end else begin
         case (m_state)
            SPIBS_M_IDLE: begin
               m_cyc <= 3'h0;
               m_bit <= 3'h0;
               if (m_start) begin
                  m_sr    <= tx_hold;
                  m_state <= SPIBS_M_SHIFT;
               end
            end
            SPIBS_M_SHIFT: begin
               m_cyc <= m_cyc + 3'h1;
               if (m_samp) begin
                  m_in <= {m_in[6:0], miso_m2}; // R8
               end
               if (m_cyc == CYC_LAST) begin
                  m_sr  <= {m_sr[6:0], 1'b1};
                  m_bit <= m_bit + 3'h1;
                  if (m_bit == BIT_LAST) begin
                     m_state <= SPIBS_M_IDLE;
                  end
               end
            end
            default: m_state <= SPIBS_M_IDLE;
         endcase
      end
   end

   // Pin drivers; enables low while driving
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SCK_O     <= 1'b0;
         MOSI_O    <= 1'b1;
         SCK_OE_N  <= 1'b1;
         MOSI_OE_N <= 1'b1;
         MISO_OE_N <= 1'b1;
      end else begin
         SCK_O     <= (m_state == SPIBS_M_SHIFT) && (m_cyc >= CYC_HALF);
         MOSI_O    <= (m_state == SPIBS_M_SHIFT) ? m_sr[7] : 1'b1;
         SCK_OE_N  <= ~MASTER_MODE;
         MOSI_OE_N <= ~MASTER_MODE;
         MISO_OE_N <= MASTER_MODE;
      end
   end

   // Finished bytes wait here until the buffer has room
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rx_cap  <= 8'h00;
         rx_pend <= 1'b0;
      end else if (m_state == SPIBS_M_SHIFT && m_cyc == CYC_LAST
                   && m_bit == BIT_LAST) begin
         rx_cap  <= m_in;
         rx_pend <= 1'b1;
      end else if (byte_evt && !MASTER_MODE) begin
         rx_cap  <= l_rx; // Stable for seven more serial edges
         rx_pend <= 1'b1;
      end else if (rxq.in_ready) begin
         rx_pend <= 1'b0;
      end
   end

   // Shift-register empty; the set beats a same-cycle clear
   always_comb begin
      next_sre = SHIFT_REG_EMPTY_FLAG;
      if (edge_evt || ack_rise) begin
         next_sre = 1'b0; // R2
      end
      if (byte_evt && TX_READY && !rx_pend) begin
         next_sre = 1'b1; // R1
      end
      if (MASTER_MODE) begin
         next_sre = 1'b1; // R3
      end
   end

   // Flags are driven by hardware only, no write path exists
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SHIFT_REG_EMPTY_FLAG <= SRE_RESET;
         RX_BUFFER_EMPTY_FLAG <= RXE_RESET;
      end else begin
         SHIFT_REG_EMPTY_FLAG <= next_sre; // R9
         RX_BUFFER_EMPTY_FLAG <= MASTER_MODE | ~rxq.out_valid; // R4 R5 R6
      end
   end

   sequence m_bit_start;
      m_state == SPIBS_M_SHIFT && m_cyc == 3'h0;
   endsequence
   sequence m_sample_late;
      ##6 m_samp ##1 (m_cyc == CYC_LAST);
   endsequence

   master_sre_a: assert property (@(posedge CLK) disable iff (RST) // R3
      MASTER_MODE |=> SHIFT_REG_EMPTY_FLAG)
      else $error("shift empty low in master mode");
   master_rxe_a: assert property (@(posedge CLK) disable iff (RST) // R6
      MASTER_MODE |=> RX_BUFFER_EMPTY_FLAG)
      else $error("rx empty low in master mode");
   sre_clear_a: assert property (@(posedge CLK) disable iff (RST) // R2
      (!MASTER_MODE && (edge_evt || ack_rise) && !byte_evt)
      |=> !SHIFT_REG_EMPTY_FLAG)
      else $error("shift empty not cleared by activity");
   sre_set_a: assert property (@(posedge CLK) disable iff (RST) // R1
      (!MASTER_MODE && byte_evt && TX_READY && !rx_pend)
      |=> SHIFT_REG_EMPTY_FLAG)
      else $error("shift empty not set after idle byte");
   rxe_set_a: assert property (@(posedge CLK) disable iff (RST) // R4
      (!MASTER_MODE && !RX_VALID) |=> RX_BUFFER_EMPTY_FLAG)
      else $error("rx empty low with nothing unread");
   rxe_clear_a: assert property (@(posedge CLK) disable iff (RST) // R5
      (!MASTER_MODE && RX_VALID && !RX_READY) |=> !RX_BUFFER_EMPTY_FLAG)
      else $error("rx empty high with byte unread");
   master_sample_a: assert property (@(posedge CLK) disable iff (RST) // R8
      m_bit_start |-> m_sample_late)
      else $error("master sample not one clock before bit end");
   slave_sample_a: assert property (@(posedge SCK_LINK) disable iff (RST) // R7
      (l_cnt == BIT_LAST) |=> (l_cnt == 3'h0 && l_rx[0] == $past(MOSI_I)))
      else $error("slave byte not built from center samples");
   flag_stable_a: assert property (@(posedge CLK) disable iff (RST) // R9
      (!MASTER_MODE && !edge_evt && !ack_rise && !byte_evt
       && $stable(MASTER_MODE)) |=> $stable(SHIFT_REG_EMPTY_FLAG))
      else $error("shift empty changed without a cause");
endmodule : spibs_top
`default_nettype wire

// ==== spibs_link_model.sv ====
// Far-side serial partner: master in slave mode, slave in master mode
`timescale 1ns/100ps
`default_nettype none
module spibs_link_model (
   output var logic sck_link, // Link clock, still outside frames
   output var logic mosi_i,   // Data to the block as slave
   output logic     miso_i,   // Data to the block as master
   input  wire logic miso_o,  // Block slave data out
   input  wire logic sck_o,   // Block master clock
   input  wire logic mosi_o   // Block master data out
);
   logic [7:0] miso_cap;    // Bits seen on the slave output
   logic [7:0] sh = 8'hff;  // Answer shift register
   logic [7:0] mosi_sh;     // Bits seen on the master output
   int         fall_cnt;    // Master clock falls in this byte
   int         rise_cnt;    // Master clock rises in this byte
   logic [7:0] miso_q[$];   // Further answer bytes
   logic [7:0] mosi_got[$]; // Bytes the block sent as master
   initial begin
      sck_link = 1'b0;
      mosi_i = 1'b1;
   end
   // One byte MSB first; data set half a bit ahead of the rise
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi_i = b[i];
         #7.5;
         miso_cap = {miso_cap[6:0], miso_o};
         sck_link = 1'b1;
         #7.5;
         sck_link = 1'b0;
      end
      // Released line must not keep showing the last bit
      mosi_i = ~mosi_i;
   endtask : send
   // Preset the answer before a master transfer
   task automatic load(input logic [7:0] b);
      sh = b;
      fall_cnt = 0;
      rise_cnt = 0;
   endtask : load
   // New bit after each fall, so it is stable at the sampling point
   always @(negedge sck_o) begin
      fall_cnt = fall_cnt + 1;
      if (fall_cnt == 8) begin
         fall_cnt = 0;
         sh = (miso_q.size() > 0) ? miso_q.pop_front() : ~sh;
      end else begin
         sh = {sh[6:0], ~sh[0]};
      end
   end
   assign miso_i = sh[7];
   // Collect what the block shifts out
   always @(posedge sck_o) begin
      mosi_sh = {mosi_sh[6:0], mosi_o};
      rise_cnt = rise_cnt + 1;
      if (rise_cnt == 8) begin
         rise_cnt = 0;
         mosi_got.push_back(mosi_sh);
      end
   end
endmodule : spibs_link_model
`default_nettype wire

// ==== spibs_top_tb_top.sv ====
// Self-checking bench for the serial port status block
`timescale 1ns/100ps
`default_nettype none
module spibs_top_tb_top;
   import spibs_pkg::*;
   logic       CLK, RST, MASTER_MODE, TX_VALID, RX_READY; // Driven here
   logic [7:0] TX_DATA;                                   // Byte offered
   logic       SCK_LINK, MOSI_I, MISO_I;                  // From partner
   logic       SCK_O, SCK_OE_N, MOSI_O, MOSI_OE_N;        // Master pins
   logic       MISO_O, MISO_OE_N, TX_READY, RX_VALID;     // Outputs
   logic [7:0] RX_DATA;                                   // Buffer head
   logic       SRE, RXE;                                  // Empty flags
   int         err_count, checks_done, cyc, seed;
   logic [7:0] exp_q[$];  // Bytes due out of the receive buffer
   logic [7:0] t, b;      // Transmit bytes
   spibs_top dut_u (.CLK(CLK), .RST(RST), .SCK_LINK(SCK_LINK),
      .MASTER_MODE(MASTER_MODE), .MOSI_I(MOSI_I), .MISO_I(MISO_I),
      .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N), .MOSI_O(MOSI_O),
      .MOSI_OE_N(MOSI_OE_N), .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N),
      .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
      .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
      .SHIFT_REG_EMPTY_FLAG(SRE), .RX_BUFFER_EMPTY_FLAG(RXE));
   spibs_link_model link_u (.sck_link(SCK_LINK), .mosi_i(MOSI_I),
      .miso_i(MISO_I), .miso_o(MISO_O), .sck_o(SCK_O), .mosi_o(MOSI_O));
   always #4 CLK = ~CLK;
   // Cuts a hang short; the run needs well under 2000 cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Take the head byte; the model queue says what it must be
   task automatic pop();
      for (int n = 0; n < 300 && RX_VALID !== 1'b1; n++) @(posedge CLK);
      check(RX_DATA, exp_q.pop_front());
      RX_READY <= 1'b1;
      @(posedge CLK);
      RX_READY <= 1'b0;
      @(posedge CLK);
   endtask : pop
   // Offer a byte and hold it until taken; valid is left high
   task automatic push_tx(input logic [7:0] d);
      TX_DATA <= d;
      TX_VALID <= 1'b1;
      do @(posedge CLK); while (TX_READY !== 1'b1);
   endtask : push_tx
   // Far master sends a byte; shift flag must drop mid-frame
   task automatic slave_byte(input logic [7:0] d);
      exp_q.push_back(d);
      fork
         #3.1 link_u.send(d);
         begin
            repeat (8) @(posedge CLK);
            check({7'h0, SRE}, 8'h00);
         end
      join
      repeat (20) @(posedge CLK);
   endtask : slave_byte
   initial begin
      CLK = 1'b0;
      RST = 1'b0;
      MASTER_MODE = 1'b0;
      TX_DATA = 8'h00;
      TX_VALID = 1'b0;
      RX_READY = 1'b0;
      seed = 93491;
      // A clean rising edge after time zero, so the idle link side resets
      #1 RST = 1'b1;
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
      check({6'h0, SRE, RXE}, 8'h03);
      check({5'h0, SCK_OE_N, MOSI_OE_N, MISO_OE_N}, 8'h06);
      // Three bytes while the reader stalls: buffer plus holding slot
      for (int i = 0; i < 3; i++) begin
         slave_byte(8'($random(seed)));
         if (i < 2) check({7'h0, SRE}, 8'h01);
      end
      check({7'h0, RXE}, 8'h00);
      repeat (3) pop();
      repeat (2) @(posedge CLK);
      check({7'h0, RXE}, 8'h01);
      // Offered byte is loaded at the end of the next frame
      t = 8'($random(seed));
      push_tx(t);
      TX_VALID <= 1'b0;
      slave_byte(8'($random(seed)));
      check(link_u.miso_cap, IDLE_BYTE);
      slave_byte(8'($random(seed)));
      check(link_u.miso_cap, t);
      check({7'h0, SRE}, 8'h01);
      repeat (2) pop();
      // Master mode: two bytes back to back, flags pinned high
      MASTER_MODE <= 1'b1;
      repeat (2) @(posedge CLK);
      check({5'h0, SCK_OE_N, MOSI_OE_N, MISO_OE_N}, 8'h01);
      exp_q.push_back(8'($random(seed)));
      exp_q.push_back(8'($random(seed)));
      link_u.load(exp_q[0]);
      link_u.miso_q.push_back(exp_q[1]);
      t = 8'($random(seed));
      b = 8'($random(seed));
      push_tx(t);
      push_tx(b);
      TX_VALID <= 1'b0;
      repeat (140) begin
         @(posedge CLK);
         check({6'h0, SRE, RXE}, 8'h03);
      end
      repeat (2) pop();
      check(link_u.mosi_got.pop_front(), t);
      check(link_u.mosi_got.pop_front(), b);
      complete_run();
   end
endmodule : spibs_top_tb_top
`default_nettype wire
